// file: core/uarx_consts.vh
// uarx_consts.vh: constants for the asynchronous uart receiver
// assumes inclusion by bare name from the fifo and receiver design files
`ifndef UARX_CONSTS_VH
`define UARX_CONSTS_VH
`define UARX_MODE_8N 4'h0
`define UARX_MODE_7N 4'h1
`define UARX_MODE_ODD 4'h2
`define UARX_MODE_EVEN 4'h3
`define UARX_MODE_ADDR 4'h4
`define UARX_NS_LAST 5'h0F
`define UARX_HS_LAST 5'h03
`define UARX_CNT_EARLY1 5'h00
`define UARX_CNT_EARLY2 5'h01
`define UARX_CNT_S7 5'h06
`define UARX_CNT_S8 5'h07
`define UARX_CNT_S9 5'h08
`define UARX_HS_MID 5'h01
`define UARX_BITS_8 4'h8
`define UARX_BITS_7 4'h7
`define UARX_BITS_9 4'h9
`define UARX_FIFO_DEPTH 2'h2
`endif

// file: core/uarx_sync.v
// uarx_sync.v: two-stage synchroniser for the receive pin
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
module uarx_sync (
  input wire clk_sys,
  input wire rst,
  input wire din,
  output reg dout
);
  reg meta_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // uarx_sync

// file: core/uarx_fifo.v
// uarx_fifo.v: two-entry receive fifo holding data plus two error flags
// assumes push is ignored by the caller when full; flush empties at once
`timescale 1ns/1ps
`include "uarx_consts.vh"
module uarx_fifo (
  input wire clk_sys,
  input wire rst,
  input wire flush,
  input wire push,
  input wire [9:0] pushData,
  input wire pop,
  output wire [9:0] topData,
  output wire empty,
  output wire full
);
  reg [9:0] mem [0:1];
  reg wrPtr_r;
  reg rdPtr_r;
  reg [1:0] count_r;
  wire doPush;
  wire doPop;
  assign empty = (count_r == 2'h0);
  assign full = (count_r == `UARX_FIFO_DEPTH);
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign topData = empty ? 10'h000 : mem[rdPtr_r];
  always @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end
  always @(posedge clk_sys) begin
    if (rst || flush) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (doPush) begin
        wrPtr_r <= ~wrPtr_r;
      end
      if (doPop) begin
        rdPtr_r <= ~rdPtr_r;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 2'h1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule // uarx_fifo

// file: core/uarx_receiver.v
// uarx_receiver.v: asynchronous uart receiver with fifo, errors, address mode
// assumes baudTick pulses once per baud generator clock, on clk_sys
`timescale 1ns/1ps
`include "uarx_consts.vh"
module uarx_receiver (
  input wire clk_sys,
  input wire rst,
  input wire rxPin,
  input wire baudTick,
  input wire highSpeed,
  input wire [3:0] mode,
  input wire moduleEnable,
  input wire receiveEnable,
  input wire receivePolarityInvert,
  input wire runOnOverflow,
  input wire framingErrorIrqEnable,
  input wire parityErrorIrqEnable,
  input wire fifoOverflowIrqEnable,
  input wire [7:0] receiverAddress,
  input wire [7:0] receiverAddressMask,
  input wire receiveDataRead,
  input wire fifoOverflowClear,
  output reg [7:0] receiveDataRegister,
  output wire receiveCharFlag,
  output wire dmaRequest,
  output wire framingErrorFlag,
  output wire parityErrorFlag,
  output reg fifoOverflowFlag,
  output wire summaryErrorFlag,
  output reg busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOP = 2'h3;

  reg [1:0] state_r;
  reg [4:0] tickCnt_r;
  reg [2:0] samp_r;
  reg earlyLow_r;
  reg [3:0] bitCnt_r;
  reg [8:0] receiveShiftRegister_r;
  reg lineLast_r;
  reg addrMatched_r;
  reg push;
  reg [9:0] pushData;
  reg ovfSet;
  wire rxSync;
  wire line;
  wire rxOn;
  wire [9:0] topData;
  wire fifoEmpty;
  wire fifoFull;
  wire suppress;
  wire [4:0] lastTick;
  wire sampleBit;
  wire stalled;

  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  function [3:0] dataBits;
    input [3:0] m;
    begin
      case (m)
        `UARX_MODE_7N: dataBits = `UARX_BITS_7;
        `UARX_MODE_ODD, `UARX_MODE_EVEN, `UARX_MODE_ADDR: dataBits = `UARX_BITS_9;
        default: dataBits = `UARX_BITS_8;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // line conditioning

  uarx_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(rxPin),
    .dout(rxSync)
  );

  assign line = rxSync ^ receivePolarityInvert;
  assign rxOn = moduleEnable && receiveEnable;
  assign stalled = fifoOverflowFlag && !runOnOverflow;
  assign lastTick = highSpeed ? `UARX_HS_LAST : `UARX_NS_LAST;
  assign sampleBit = highSpeed ? samp_r[1] : maj3(samp_r);

  ////////////////////////////////////////////////////////////////////////////
  // data recovery

  always @(posedge clk_sys) begin
    if (rst || !rxOn) begin
      state_r <= ST_IDLE;
      tickCnt_r <= 5'h00;
      samp_r <= 3'h7;
      earlyLow_r <= 1'b0;
      bitCnt_r <= 4'h0;
      receiveShiftRegister_r <= 9'h000;
      lineLast_r <= 1'b1;
      busy <= 1'b0;
    end else begin
      lineLast_r <= line;
      case (state_r)
        ST_IDLE: begin
          busy <= 1'b0;
          if (lineLast_r && !line && !stalled) begin
            state_r <= ST_START;
            tickCnt_r <= 5'h00;
            earlyLow_r <= highSpeed;
            busy <= 1'b1;
          end
        end
        ST_START: begin
          if (baudTick) begin
            tickCnt_r <= tickCnt_r + 5'h01;
            if (!highSpeed && tickCnt_r == `UARX_CNT_EARLY1) begin
              earlyLow_r <= !line;
            end
            if (!highSpeed && tickCnt_r == `UARX_CNT_EARLY2 && earlyLow_r == 1'b0
                && line) begin
              state_r <= ST_IDLE;
            end
            if (!highSpeed && tickCnt_r == `UARX_CNT_S7) samp_r[0] <= line;
            if (!highSpeed && tickCnt_r == `UARX_CNT_S8) samp_r[1] <= line;
            if (!highSpeed && tickCnt_r == `UARX_CNT_S9) samp_r[2] <= line;
            if (highSpeed && tickCnt_r == `UARX_HS_MID) samp_r[1] <= line;
            if (tickCnt_r == lastTick) begin
              tickCnt_r <= 5'h00;
              if (sampleBit) begin
                state_r <= ST_IDLE;
              end else begin
                state_r <= ST_DATA;
                bitCnt_r <= 4'h0;
              end
            end
          end
        end
        ST_DATA, ST_STOP: begin
          if (baudTick) begin
            tickCnt_r <= tickCnt_r + 5'h01;
            if (!highSpeed && tickCnt_r == `UARX_CNT_S7) samp_r[0] <= line;
            if (!highSpeed && tickCnt_r == `UARX_CNT_S8) samp_r[1] <= line;
            if (!highSpeed && tickCnt_r == `UARX_CNT_S9) samp_r[2] <= line;
            if (highSpeed && tickCnt_r == `UARX_HS_MID) samp_r[1] <= line;
            if (tickCnt_r == lastTick) begin
              tickCnt_r <= 5'h00;
              if (state_r == ST_STOP) begin
                state_r <= ST_IDLE;
              end else begin
                // lsb first: shift right, top aligned then fixed at push
                receiveShiftRegister_r <= {sampleBit, receiveShiftRegister_r[8:1]};
                bitCnt_r <= bitCnt_r + 4'h1;
                if (bitCnt_r + 4'h1 == dataBits(mode)) begin
                  state_r <= ST_STOP;
                end
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character completion, parity, address filter

  wire charDone;
  wire stopBit;
  wire [8:0] aligned;
  wire [7:0] dataByte;
  wire ninth;
  wire parityErr;
  wire isAddrMode;
  wire addrHit;
  assign charDone = (state_r == ST_STOP) && baudTick && (tickCnt_r == lastTick) && rxOn;
  assign stopBit = sampleBit;
  assign aligned = (mode == `UARX_MODE_7N) ? {2'h0, receiveShiftRegister_r[8:2]} :
                   (dataBits(mode) == `UARX_BITS_9) ? receiveShiftRegister_r :
                   {1'b0, receiveShiftRegister_r[8:1]};
  assign dataByte = aligned[7:0];
  assign ninth = aligned[8];
  assign isAddrMode = (mode == `UARX_MODE_ADDR);
  assign parityErr = (mode == `UARX_MODE_EVEN) ? ^aligned :
                     (mode == `UARX_MODE_ODD) ? ~^aligned : 1'b0;
  assign addrHit = (((dataByte ^ receiverAddress) & receiverAddressMask) == 8'h00);

  always @* begin
    push = 1'b0;
    ovfSet = 1'b0;
    pushData = {!stopBit, isAddrMode ? ninth : parityErr, dataByte};
    if (charDone) begin
      if (!isAddrMode || (ninth ? addrHit : addrMatched_r)) begin
        if (fifoFull || fifoOverflowFlag) begin
          ovfSet = 1'b1;
        end else begin
          push = 1'b1;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst || !rxOn) begin
      addrMatched_r <= 1'b0;
    end else if (charDone && isAddrMode && ninth) begin
      addrMatched_r <= addrHit;
    end
  end

  always @(posedge clk_sys) begin
    if (rst || !moduleEnable) begin
      fifoOverflowFlag <= 1'b0;
    end else if (ovfSet) begin
      fifoOverflowFlag <= 1'b1; // set wins over clear
    end else if (fifoOverflowClear) begin
      fifoOverflowFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo and status

  uarx_fifo u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(!moduleEnable),
    .push(push),
    .pushData(pushData),
    .pop(receiveDataRead),
    .topData(topData),
    .empty(fifoEmpty),
    .full(fifoFull)
  );

  always @(posedge clk_sys) begin
    if (rst) begin
      receiveDataRegister <= 8'h00;
    end else if (receiveDataRead && !fifoEmpty) begin
      receiveDataRegister <= topData[7:0];
    end
  end

  assign framingErrorFlag = topData[9];
  assign parityErrorFlag = topData[8];
  assign suppress = (framingErrorFlag && framingErrorIrqEnable) ||
                    (parityErrorFlag && parityErrorIrqEnable);
  assign receiveCharFlag = !fifoEmpty && !suppress;
  assign dmaRequest = receiveCharFlag;
  assign summaryErrorFlag = suppress || (fifoOverflowFlag && fifoOverflowIrqEnable);
endmodule // uarx_receiver

// file: tb/uarx_receiver_properties.sv
// uarx_receiver_properties.sv: port assertions for the uart receiver
// assumes it is bound onto uarx_receiver, one clock domain
`timescale 1ns/1ps
module uarx_receiver_properties (
  input wire clk_sys,
  input wire rst,
  input wire moduleEnable,
  input wire receiveEnable,
  input wire framingErrorIrqEnable,
  input wire parityErrorIrqEnable,
  input wire fifoOverflowIrqEnable,
  input wire fifoOverflowClear,
  input wire receiveCharFlag,
  input wire dmaRequest,
  input wire framingErrorFlag,
  input wire parityErrorFlag,
  input wire fifoOverflowFlag,
  input wire summaryErrorFlag,
  input wire busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  dma_follows_a: assert property (dmaRequest == receiveCharFlag)
    else $error("dma request differs from receive flag");
  fe_suppress_a: assert property (framingErrorFlag && framingErrorIrqEnable
    |-> !receiveCharFlag)
    else $error("receive flag not suppressed by framing error");
  pe_suppress_a: assert property (parityErrorFlag && parityErrorIrqEnable
    |-> !receiveCharFlag)
    else $error("receive flag not suppressed by parity error");
  err_summary_a: assert property ((framingErrorFlag && framingErrorIrqEnable)
    || (parityErrorFlag && parityErrorIrqEnable) |-> summaryErrorFlag)
    else $error("summary error missing for top entry error");
  ovf_summary_a: assert property (fifoOverflowFlag && fifoOverflowIrqEnable
    |-> summaryErrorFlag)
    else $error("summary error missing for overflow");
  summary_cause_a: assert property (summaryErrorFlag
    |-> (framingErrorFlag && framingErrorIrqEnable) || (parityErrorFlag && parityErrorIrqEnable)
    || (fifoOverflowFlag && fifoOverflowIrqEnable))
    else $error("summary error without cause");
  ovf_sticky_a: assert property (fifoOverflowFlag && !fifoOverflowClear && moduleEnable
    |=> fifoOverflowFlag)
    else $error("overflow flag dropped without clear");
  off_flush_a: assert property (!moduleEnable
    |=> !receiveCharFlag && !framingErrorFlag && !fifoOverflowFlag)
    else $error("module disable did not empty the fifo");
  rx_off_idle_a: assert property (!receiveEnable || !moduleEnable |=> !busy)
    else $error("receiver busy while disabled");
  reset_clean_a: assert property ($fell(rst)
    |-> !receiveCharFlag && !busy && !fifoOverflowFlag && !summaryErrorFlag)
    else $error("state not clean after reset");
endmodule // uarx_receiver_properties
bind uarx_receiver uarx_receiver_properties uarx_receiver_properties_inst (
  .clk_sys(clk_sys), .rst(rst), .moduleEnable(moduleEnable), .receiveEnable(receiveEnable),
  .framingErrorIrqEnable(framingErrorIrqEnable), .parityErrorIrqEnable(parityErrorIrqEnable),
  .fifoOverflowIrqEnable(fifoOverflowIrqEnable), .fifoOverflowClear(fifoOverflowClear),
  .receiveCharFlag(receiveCharFlag), .dmaRequest(dmaRequest), .busy(busy),
  .framingErrorFlag(framingErrorFlag), .parityErrorFlag(parityErrorFlag),
  .fifoOverflowFlag(fifoOverflowFlag), .summaryErrorFlag(summaryErrorFlag));

// file: tb/uarx_tx_model.sv
// uarx_tx_model.sv: remote serial transmitter driving the receive pin
// assumes baudTick pulses on clk_sys, sixteen ticks per bit, four when fast
`timescale 1ns/1ps
module uarx_tx_model (
  input wire clk_sys,
  input wire baudTick,
  input wire invert,
  input wire fast,
  output wire line
);
  reg active = 1'b0;
  reg bitVal = 1'b1;
  integer i;
  integer k;
  // idle level follows the polarity setting
  assign line = active ? bitVal ^ invert : !invert;
  task send(input [11:0] f, input integer n);
    begin
      active = 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        bitVal = f[i];
        k = 0;
        while (k < (fast ? 4 : 16)) begin
          @(posedge clk_sys);
          if (baudTick) k = k + 1;
        end
        #1;
      end
      active = 1'b0;
    end
  endtask
endmodule // uarx_tx_model

// file: tb/uarx_receiver_test.sv
// uarx_receiver_test.sv: self-checking bench for the uart receiver
// assumes uarx_tx_model as the far side, baud tick every other clock
`timescale 1ns/1ps
module uarx_receiver_test;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg baudTick = 1'b0;
  reg [3:0] mode = 4'h0;
  reg highSpeed = 1'b0, moduleEnable = 1'b1, receiveEnable = 1'b1, receivePolarityInvert = 1'b0;
  reg runOnOverflow = 1'b0, framingErrorIrqEnable = 1'b0, parityErrorIrqEnable = 1'b0;
  reg fifoOverflowIrqEnable = 1'b0, receiveDataRead = 1'b0, fifoOverflowClear = 1'b0;
  wire rxPin, receiveCharFlag, dmaRequest, framingErrorFlag, parityErrorFlag;
  wire fifoOverflowFlag, summaryErrorFlag, busy;
  wire [7:0] receiveDataRegister;
  integer error_cnt = 0;
  integer compares = 0;
  integer i;
  integer k;
  reg [7:0] rnd = 8'h4F;
  reg [9:0] expQ[$];
  reg [9:0] e;
  uarx_receiver uarx_receiver_inst (.clk_sys(clk_sys), .rst(rst), .rxPin(rxPin),
    .baudTick(baudTick), .highSpeed(highSpeed), .mode(mode), .moduleEnable(moduleEnable),
    .receiveEnable(receiveEnable), .receivePolarityInvert(receivePolarityInvert),
    .runOnOverflow(runOnOverflow), .framingErrorIrqEnable(framingErrorIrqEnable),
    .parityErrorIrqEnable(parityErrorIrqEnable), .fifoOverflowIrqEnable(fifoOverflowIrqEnable),
    .receiverAddress(8'h5A), .receiverAddressMask(8'hF0), .receiveDataRead(receiveDataRead),
    .fifoOverflowClear(fifoOverflowClear), .receiveDataRegister(receiveDataRegister),
    .receiveCharFlag(receiveCharFlag), .dmaRequest(dmaRequest), .busy(busy),
    .framingErrorFlag(framingErrorFlag), .parityErrorFlag(parityErrorFlag),
    .fifoOverflowFlag(fifoOverflowFlag), .summaryErrorFlag(summaryErrorFlag));
  uarx_tx_model uarx_tx_model_inst (.clk_sys(clk_sys), .baudTick(baudTick),
    .invert(receivePolarityInvert), .fast(highSpeed), .line(rxPin));
  always #20 clk_sys = !clk_sys;
  always @(posedge clk_sys) #1 baudTick = !baudTick;
  ////////////////////////////////////////////////////////////////////////////////
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task chk(input [9:0] got, input [9:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ext holds stop then ninth bit; flags are parity then framing
  task sendChar(input [7:0] d, input [1:0] ext, input integer n, input [1:0] fl, input st);
    begin
      uarx_tx_model_inst.send((n == 11) ? {1'b0, ext, d, 1'b0} : {2'b00, ext[1], d, 1'b0}, n);
      for (i = 0; i < 100 && busy !== 1'b0; i = i + 1) tick;
      if (busy !== 1'b0) begin
        error_cnt = error_cnt + 1;
        print_verdict;
      end
      repeat (2) tick;
      if (st) expQ.push_back({fl, d});
    end
  endtask
  task readCheck;
    begin
      e = expQ.pop_front();
      chk({8'h00, parityErrorFlag, framingErrorFlag}, {8'h00, e[9:8]});
      receiveDataRead = 1'b1;
      tick;
      receiveDataRead = 1'b0;
      chk({2'b00, receiveDataRegister}, {2'b00, e[7:0]});
      tick;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial begin
    repeat (2) tick;
    rst = 1'b0;
    repeat (4) tick;
    for (k = 0; k < 3; k = k + 1) begin
      rnd = lfsr(rnd);
      sendChar(rnd, 2'b10, 10, 2'b00, 1'b1);
      chk({9'h000, receiveCharFlag}, 10'h001);
      readCheck;
    end
    highSpeed = 1'b1;
    repeat (4) tick;
    rnd = lfsr(rnd);
    sendChar(rnd, 2'b10, 10, 2'b00, 1'b1);
    readCheck;
    highSpeed = 1'b0;
    mode = 4'h1;
    repeat (4) tick;
    rnd = lfsr(rnd);
    sendChar({1'b1, rnd[6:0]}, 2'b10, 9, 2'b00, 1'b0);
    expQ.push_back({3'b000, rnd[6:0]});
    readCheck;
    mode = 4'h0;
    framingErrorIrqEnable = 1'b1;
    sendChar(8'h00, 2'b00, 10, 2'b01, 1'b1);
    chk({8'h00, receiveCharFlag, summaryErrorFlag}, 10'h001);
    readCheck;
    chk({8'h00, framingErrorFlag, summaryErrorFlag}, 10'h000);
    parityErrorIrqEnable = 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      mode = k[1] ? 4'h3 : 4'h2;
      rnd = lfsr(rnd);
      sendChar(rnd, {1'b1, ^rnd ^ !k[1] ^ k[0]}, 11, {k[0], 1'b0}, 1'b1);
      chk({9'h000, receiveCharFlag}, {9'h000, !k[0]});
      readCheck;
    end
    mode = 4'h0;
    fifoOverflowIrqEnable = 1'b1;
    runOnOverflow = 1'b1;
    for (k = 0; k < 3; k = k + 1) begin
      rnd = lfsr(rnd);
      sendChar(rnd, 2'b10, 10, 2'b00, k < 2);
    end
    chk({8'h00, fifoOverflowFlag, summaryErrorFlag}, 10'h003);
    readCheck;
    readCheck;
    fifoOverflowClear = 1'b1;
    tick;
    fifoOverflowClear = 1'b0;
    chk({9'h000, fifoOverflowFlag}, 10'h000);
    mode = 4'h4;
    sendChar(8'h11, 2'b10, 11, 2'b00, 1'b0);
    sendChar(8'h3A, 2'b11, 11, 2'b10, 1'b0);
    sendChar(8'h55, 2'b11, 11, 2'b10, 1'b1);
    sendChar(8'h12, 2'b10, 11, 2'b00, 1'b1);
    sendChar(8'h00, 2'b11, 11, 2'b10, 1'b0);
    sendChar(8'h13, 2'b10, 11, 2'b00, 1'b0);
    readCheck;
    readCheck;
    mode = 4'h0;
    receivePolarityInvert = 1'b1;
    repeat (40) tick;
    rnd = lfsr(rnd);
    sendChar(rnd, 2'b10, 10, 2'b00, 1'b1);
    readCheck;
    sendChar(rnd, 2'b10, 10, 2'b00, 1'b0);
    moduleEnable = 1'b0;
    tick;
    moduleEnable = 1'b1;
    chk({9'h000, receiveCharFlag}, 10'h000);
    receiveEnable = 1'b0;
    sendChar(rnd, 2'b10, 10, 2'b00, 1'b0);
    chk({8'h00, receiveCharFlag, busy}, 10'h000);
    print_verdict;
  end
endmodule // uarx_receiver_test
